// ### rtl/crx_map.svh
// Register offsets, field positions, reset values and counts for the CAN receive block
// ====================================================================
// Contract
// [RULE_01] First accepted message shows, count becomes 01b
// [RULE_02] Release empties or shows next pending message
// [RULE_03] Further messages advance count to 10b, 11b
// [RULE_04] Fourth pending message is overrun, sets flag
// [RULE_05] Lock clear overwrites last; set discards new
// [RULE_06] Count 00b to 01b requests pending interrupt
// [RULE_07] Third stored sets full, requests interrupt
// [RULE_08] Overrun requests interrupt when enabled
// [RULE_09] Six filter banks of eight byte registers
// [RULE_10] Unaccepted messages dropped by hardware alone
// [RULE_11] 32-bit scale: std, IDE, ext, RTR; the code packs std, ext, IDE, RTR
// [RULE_12] 16-bit scale: two filters, std, RTR, IDE
// [RULE_13] 8-bit scale: four filters, std 10:3
// [RULE_14] Mixed scale: one 16-bit, two 8-bit
// [RULE_15] Mask mode: mask bit marks must-match
// [RULE_16] List mode: mask register is second identifier
// [RULE_17] Sync segment lasts exactly one quantum
// [RULE_18] Segment one 1..16, lengthened on resync
// [RULE_19] Segment two 1..8, shortened on resync
// [RULE_20] Jump width 1..4 caps any adjustment
// [RULE_21] Software keeps bit total at least five
// [RULE_22] Timing registers writable only in init mode
// [RULE_23] Simultaneous release and store both counted
`ifndef CRX_MAP_SVH
`define CRX_MAP_SVH
// ====================================================================
// Byte offsets; CRX_FILT_BASE is the word index of the first filter register
`define CRX_OFS_MCR      8'h00
`define CRX_OFS_IER      8'h04
`define CRX_OFS_FIFO     8'h08
`define CRX_OFS_BTRA     8'h0C
`define CRX_OFS_BTRB     8'h10
`define CRX_OFS_FMODE    8'h14
`define CRX_OFS_MB_ID    8'h18
`define CRX_OFS_MB_DLC   8'h1C
`define CRX_OFS_MB_DLO   8'h20
`define CRX_OFS_MB_DHI   8'h24
`define CRX_FILT_BASE    6'h10
// ====================================================================
// Field positions
`define CRX_MCR_INIT     0
`define CRX_MCR_LOCK     1
`define CRX_IER_PEND     0
`define CRX_IER_FULL     1
`define CRX_IER_OVR      2
`define CRX_FIFO_FULL    3
`define CRX_FIFO_OVR     4
`define CRX_FIFO_REL     5
`define CRX_FMODE_SCALE  6
// ====================================================================
// Reset values and filter compare masks
`define CRX_MCR_RST      2'h1
`define CRX_BTRA_RST     8'h00
`define CRX_BTRB_RST     7'h23
`define CRX_CARE32       32'hFFFF_FFFE
`define CRX_CARE16       32'h0000_FFF8
`define CRX_CARE8        32'h0000_00FF
`define CRX_NUM_BANKS    6
`define CRX_NUM_FILT     48
`endif

// ### rtl/crx_pkg.sv
// Types shared by the CAN receive block
package crx_pkg;
    typedef enum logic [1:0] {
        CRX_BT_SYNC = 2'b00,
        CRX_BT_SEG1 = 2'b01,
        CRX_BT_SEG2 = 2'b10
    } crx_bt_state_t;

    typedef enum logic [1:0] {
        CRX_SC_8   = 2'b00,
        CRX_SC_16  = 2'b01,
        CRX_SC_32  = 2'b10,
        CRX_SC_MIX = 2'b11
    } crx_scale_t;

    typedef struct packed {
        logic [10:0] std_id;
        logic [17:0] ext_id;
        logic        ide;
        logic        rtr;
        logic [3:0]  dlc;
        logic [63:0] data;
    } crx_msg_t;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [7:0]  address;
        logic [31:0] writedata;
    } crx_avs_req_t;
endpackage : crx_pkg

// ### rtl/crx_top.sv
// CAN receive FIFO, identifier filter banks and bit timing with Avalon-MM registers
//
// The implementer's own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "crx_map.svh"
module crx_top (
    // Clock, reset, enable
    input  wire logic                i_clk_sys,
    input  wire logic                i_sys_rst,
    input  wire logic                i_ce,
    // Avalon-MM slave
    input  wire crx_pkg::crx_avs_req_t i_avs,
    output logic [31:0]              o_avs_readdata,
    output logic                     o_avs_waitrequest,
    // Decoded frames from the protocol engine
    input  wire logic                i_rx_valid,
    input  wire crx_pkg::crx_msg_t   i_rx_msg,
    // Bus line
    input  wire logic                i_can_rx,
    input  wire logic                i_bus_idle,
    // Status and events
    output logic                     o_init_mode,
    output logic [1:0]               o_fifo_count,
    output logic                     o_sample_pulse,
    output logic                     o_sample_bit,
    output logic                     o_tx_point,
    output logic                     o_irq_pending,
    output logic                     o_irq_full,
    output logic                     o_irq_overrun
);
    // ================================================================
    // Helpers
    function automatic logic [1:0] wrap3(input logic [1:0] b, input logic [1:0] o);
        logic [2:0] s;
        s = {1'b0, b} + {1'b0, o};
        wrap3 = (s >= 3'd3) ? 2'(s - 3'd3) : s[1:0];
    endfunction : wrap3

    function automatic logic hitw(input logic [31:0] id, input logic [31:0] mk,
                                  input logic [31:0] w, input logic [31:0] care,
                                  input logic lst);
        if (lst)
            hitw = (((w ^ id) & care) == 32'h0000_0000) ||
                   (((w ^ mk) & care) == 32'h0000_0000); // RULE_16
        else
            hitw = (((w ^ id) & mk & care) == 32'h0000_0000); // RULE_15
    endfunction : hitw

    // ================================================================
    // Avalon-MM slave: one wait cycle, then the access completes
    logic        wait_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rd_mux;
    logic [1:0]  mcr_reg;
    logic [2:0]  ier_reg;
    logic [7:0]  btra_reg;
    logic [6:0]  btrb_reg;
    logic [17:0] fmode_reg;
    logic [7:0]  filt_reg [0:`CRX_NUM_FILT-1];
    logic [1:0]  cnt_reg;
    logic [1:0]  rd_ptr_reg;
    logic        full_reg;
    logic        ovr_reg;
    crx_pkg::crx_msg_t mb_mem [0:2];
    crx_pkg::crx_msg_t mb_out;

    wire       req     = i_avs.read | i_avs.write;
    wire       wr_acc  = i_ce & i_avs.write & ~wait_reg;
    wire [5:0] widx    = i_avs.address[7:2];
    wire       is_filt = i_avs.address[7:6] != 2'b00;
    wire [5:0] fidx    = widx - `CRX_FILT_BASE;
    wire       wr_mcr  = wr_acc && i_avs.address == `CRX_OFS_MCR;
    wire       wr_ier  = wr_acc && i_avs.address == `CRX_OFS_IER;
    wire       wr_fifo = wr_acc && i_avs.address == `CRX_OFS_FIFO;
    wire       wr_btra = wr_acc && i_avs.address == `CRX_OFS_BTRA;
    wire       wr_btrb = wr_acc && i_avs.address == `CRX_OFS_BTRB;
    wire       wr_fm   = wr_acc && i_avs.address == `CRX_OFS_FMODE;
    wire       init    = mcr_reg[`CRX_MCR_INIT];

    assign mb_out = mb_mem[rd_ptr_reg];

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst)
            wait_reg <= 1'b1;
        else if (i_ce)
            wait_reg <= ~(req & wait_reg);
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (is_filt)
            rd_mux = {24'h00_0000, filt_reg[fidx]};
        else begin
            case (i_avs.address)
                `CRX_OFS_MCR:    rd_mux = {30'h0, mcr_reg};
                `CRX_OFS_IER:    rd_mux = {29'h0, ier_reg};
                `CRX_OFS_FIFO:   rd_mux = {27'h0, ovr_reg, full_reg, 1'b0, cnt_reg};
                `CRX_OFS_BTRA:   rd_mux = {24'h00_0000, btra_reg};
                `CRX_OFS_BTRB:   rd_mux = {25'h0, btrb_reg};
                `CRX_OFS_FMODE:  rd_mux = {14'h0, fmode_reg};
                `CRX_OFS_MB_ID:  rd_mux = {1'b0, mb_out.ext_id, mb_out.rtr, mb_out.ide,
                                           mb_out.std_id};
                `CRX_OFS_MB_DLC: rd_mux = {28'h000_0000, mb_out.dlc};
                `CRX_OFS_MB_DLO: rd_mux = mb_out.data[31:0];
                `CRX_OFS_MB_DHI: rd_mux = mb_out.data[63:32];
                default:         rd_mux = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst)
            rdata_reg <= 32'h0000_0000;
        else if (i_ce && i_avs.read && wait_reg)
            rdata_reg <= rd_mux;
    end

    assign o_avs_readdata    = rdata_reg;
    assign o_avs_waitrequest = wait_reg;

    // ================================================================
    // Control registers
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            mcr_reg   <= `CRX_MCR_RST;
            ier_reg   <= 3'h0;
            fmode_reg <= 18'h0_0000;
        end else begin
            if (wr_mcr)
                mcr_reg <= i_avs.writedata[1:0];
            if (wr_ier)
                ier_reg <= i_avs.writedata[2:0];
            if (wr_fm)
                fmode_reg <= i_avs.writedata[17:0];
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            btra_reg <= `CRX_BTRA_RST;
            btrb_reg <= `CRX_BTRB_RST;
        end else begin
            if (wr_btra && init)
                btra_reg <= i_avs.writedata[7:0]; // RULE_22
            if (wr_btrb && init)
                btrb_reg <= i_avs.writedata[6:0]; // RULE_22
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            for (int k = 0; k < `CRX_NUM_FILT; k++)
                filt_reg[k] <= 8'h00;
        end else if (wr_acc && is_filt)
            filt_reg[fidx] <= i_avs.writedata[7:0]; // RULE_09
    end

    assign o_init_mode = mcr_reg[`CRX_MCR_INIT];

    // ================================================================
    // Identifier filter banks
    logic [`CRX_NUM_BANKS-1:0] bank_hit;
    wire [31:0] w32 = {i_rx_msg.std_id, i_rx_msg.ext_id, i_rx_msg.ide, i_rx_msg.rtr, 1'b0};
    wire [31:0] w16 = {16'h0000, i_rx_msg.std_id, i_rx_msg.rtr, i_rx_msg.ide, 3'b000};
    wire [31:0] w8  = {24'h00_0000, i_rx_msg.std_id[10:3]};

    for (genvar b = 0; b < `CRX_NUM_BANKS; b++) begin : g_bank
        wire [31:0] id32 = {filt_reg[b*8], filt_reg[b*8+1], filt_reg[b*8+2], filt_reg[b*8+3]};
        wire [31:0] mk32 = {filt_reg[b*8+4], filt_reg[b*8+5], filt_reg[b*8+6],
                            filt_reg[b*8+7]};
        wire        lst  = fmode_reg[b];
        wire        h32  = hitw(id32, mk32, w32, `CRX_CARE32, lst); // RULE_11
        wire        h16a = hitw({16'h0, id32[31:16]}, {16'h0, id32[15:0]}, w16,
                                `CRX_CARE16, lst); // RULE_12
        wire        h16b = hitw({16'h0, mk32[31:16]}, {16'h0, mk32[15:0]}, w16,
                                `CRX_CARE16, lst); // RULE_12
        wire        h8a  = hitw({24'h0, id32[31:24]}, {24'h0, id32[23:16]}, w8,
                                `CRX_CARE8, lst); // RULE_13
        wire        h8b  = hitw({24'h0, id32[15:8]}, {24'h0, id32[7:0]}, w8,
                                `CRX_CARE8, lst); // RULE_13
        wire        h8c  = hitw({24'h0, mk32[31:24]}, {24'h0, mk32[23:16]}, w8,
                                `CRX_CARE8, lst); // RULE_13
        wire        h8d  = hitw({24'h0, mk32[15:8]}, {24'h0, mk32[7:0]}, w8,
                                `CRX_CARE8, lst); // RULE_13
        wire [1:0]  scale = fmode_reg[`CRX_FMODE_SCALE + 2*b +: 2];
        always_comb begin
            case (crx_pkg::crx_scale_t'(scale))
                crx_pkg::CRX_SC_8:   bank_hit[b] = h8a | h8b | h8c | h8d;
                crx_pkg::CRX_SC_16:  bank_hit[b] = h16a | h16b;
                crx_pkg::CRX_SC_32:  bank_hit[b] = h32;
                crx_pkg::CRX_SC_MIX: bank_hit[b] = h16a | h8c | h8d; // RULE_14
                default:             bank_hit[b] = 1'b0;
            endcase
        end
    end

    // ================================================================
    // Receive FIFO, three mailboxes
    wire       lock     = mcr_reg[`CRX_MCR_LOCK];
    wire       store    = i_rx_valid & (|bank_hit); // RULE_10
    wire       rel      = wr_fifo & i_avs.writedata[`CRX_FIFO_REL] & (cnt_reg != 2'd0);
    wire       room     = (cnt_reg != 2'd3) | rel;
    wire       store_ok = store & room;
    wire       ovr      = store & ~room; // RULE_04
    wire [1:0] wr_idx   = wrap3(rd_ptr_reg, cnt_reg);
    wire [1:0] last_idx = wrap3(rd_ptr_reg, 2'd2);
    logic [1:0] cnt_next;

    always_comb begin
        case ({store_ok, rel})
            2'b10:   cnt_next = 2'(cnt_reg + 2'd1); // RULE_01 RULE_03
            2'b01:   cnt_next = 2'(cnt_reg - 2'd1); // RULE_02
            default: cnt_next = cnt_reg; // RULE_23
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_ce) begin
            if (store_ok)
                mb_mem[wr_idx] <= i_rx_msg; // RULE_01 RULE_03
            else if (ovr && !lock)
                mb_mem[last_idx] <= i_rx_msg; // RULE_05
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cnt_reg    <= 2'd0;
            rd_ptr_reg <= 2'd0;
            full_reg   <= 1'b0;
        end else if (i_ce) begin
            cnt_reg  <= cnt_next;
            full_reg <= cnt_next == 2'd3; // RULE_07
            if (rel)
                rd_ptr_reg <= wrap3(rd_ptr_reg, 2'd1); // RULE_02
        end
    end

    // Overrun flag: write one clears, a new overrun in the same cycle wins
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst)
            ovr_reg <= 1'b0;
        else if (i_ce) begin
            if (ovr)
                ovr_reg <= 1'b1; // RULE_04
            else if (wr_fifo && i_avs.writedata[`CRX_FIFO_OVR])
                ovr_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_irq_pending <= 1'b0;
            o_irq_full    <= 1'b0;
            o_irq_overrun <= 1'b0;
        end else if (i_ce) begin
            o_irq_pending <= ier_reg[`CRX_IER_PEND] & (cnt_reg == 2'd0) & store_ok; // RULE_06
            o_irq_full    <= ier_reg[`CRX_IER_FULL] & store_ok & (cnt_next == 2'd3); // RULE_07
            o_irq_overrun <= ier_reg[`CRX_IER_OVR] & ovr; // RULE_08
        end
    end

    assign o_fifo_count = cnt_reg;

    // ================================================================
    // Bit timing
    crx_pkg::crx_bt_state_t bt_state;
    logic [5:0] presc_cnt;
    logic [4:0] seg_cnt;
    logic [4:0] len1_reg;
    logic [4:0] len2_reg;
    logic       rx_prev;
    logic       edge_pend;
    logic       synced;
    wire        tq     = presc_cnt == btra_reg[5:0];
    wire        edge_n = rx_prev & ~i_can_rx;
    wire        ed     = edge_n | edge_pend;
    wire        ed_ok  = ed & ~synced;
    wire [4:0]  len1   = {1'b0, btrb_reg[3:0]} + 5'd1; // RULE_18
    wire [4:0]  len2   = {2'b00, btrb_reg[6:4]} + 5'd1; // RULE_19
    wire [4:0]  sjw    = {3'b000, btra_reg[7:6]} + 5'd1; // RULE_20
    wire [4:0]  cnt1   = seg_cnt + 5'd1;
    wire [4:0]  lead   = (cnt1 < sjw) ? cnt1 : sjw; // RULE_20
    wire [4:0]  l1e    = ed_ok ? 5'(len1_reg + lead) : len1_reg; // RULE_18
    wire [4:0]  rem2   = 5'(len2_reg - cnt1);
    wire [4:0]  l2e    = ed_ok ? 5'(len2_reg - sjw) : len2_reg; // RULE_19

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rx_prev   <= 1'b1;
            edge_pend <= 1'b0;
            presc_cnt <= 6'd0;
        end else if (i_ce) begin
            rx_prev   <= i_can_rx;
            edge_pend <= edge_n | (edge_pend & ~tq);
            presc_cnt <= (tq || init) ? 6'd0 : 6'(presc_cnt + 6'd1);
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            bt_state       <= crx_pkg::CRX_BT_SYNC;
            seg_cnt        <= 5'd0;
            len1_reg       <= 5'd1;
            len2_reg       <= 5'd1;
            synced         <= 1'b0;
            o_sample_pulse <= 1'b0;
            o_sample_bit   <= 1'b1;
            o_tx_point     <= 1'b0;
        end else if (i_ce) begin
            o_sample_pulse <= 1'b0;
            o_tx_point     <= 1'b0;
            if (init) begin
                bt_state <= crx_pkg::CRX_BT_SYNC;
                seg_cnt  <= 5'd0;
                synced   <= 1'b0;
            end else if (tq) begin
                if (ed && i_bus_idle) begin
                    bt_state <= crx_pkg::CRX_BT_SEG1;
                    seg_cnt  <= 5'd0;
                    len1_reg <= len1;
                    synced   <= 1'b1;
                end else begin
                    case (bt_state)
                        crx_pkg::CRX_BT_SYNC: begin
                            bt_state <= crx_pkg::CRX_BT_SEG1; // RULE_17
                            seg_cnt  <= 5'd0;
                            len1_reg <= len1;
                        end
                        crx_pkg::CRX_BT_SEG1: begin
                            if (ed_ok) begin
                                len1_reg <= l1e; // RULE_18
                                synced   <= 1'b1;
                            end
                            if (cnt1 >= l1e) begin
                                bt_state       <= crx_pkg::CRX_BT_SEG2;
                                seg_cnt        <= 5'd0;
                                len2_reg       <= len2;
                                o_sample_pulse <= 1'b1;
                                o_sample_bit   <= i_can_rx;
                            end else
                                seg_cnt <= cnt1;
                        end
                        crx_pkg::CRX_BT_SEG2: begin
                            if (ed_ok && rem2 <= sjw) begin
                                bt_state   <= crx_pkg::CRX_BT_SEG1; // RULE_19
                                seg_cnt    <= 5'd0;
                                len1_reg   <= len1;
                                synced     <= 1'b1;
                                o_tx_point <= 1'b1;
                            end else begin
                                if (ed_ok) begin
                                    len2_reg <= l2e; // RULE_19
                                    synced   <= 1'b1;
                                end
                                if (cnt1 >= l2e) begin
                                    bt_state   <= crx_pkg::CRX_BT_SYNC;
                                    seg_cnt    <= 5'd0;
                                    synced     <= 1'b0;
                                    o_tx_point <= 1'b1;
                                end else
                                    seg_cnt <= cnt1;
                            end
                        end
                        default: bt_state <= crx_pkg::CRX_BT_SYNC;
                    endcase
                end
            end
        end
    end

    // ================================================================
    // Assertions
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);

    fifo_first_a: assert property (i_ce && store && cnt_reg == 2'd0 |=> cnt_reg == 2'd1 &&
        mb_out == $past(i_rx_msg)) else $error("first message not shown"); // RULE_01
    fifo_release_a: assert property (i_ce && rel && !store |=>
        cnt_reg == 2'($past(cnt_reg) - 2'd1)) else $error("release lost"); // RULE_02
    fifo_advance_a: assert property (i_ce && store && !rel && cnt_reg != 2'd0 &&
        cnt_reg != 2'd3 |=> cnt_reg == 2'($past(cnt_reg) + 2'd1))
        else $error("count did not advance"); // RULE_03
    overrun_flag_a: assert property (i_ce && ovr |=> ovr_reg && cnt_reg == 2'd3)
        else $error("overrun not flagged"); // RULE_04
    lock_discard_a: assert property (i_ce && ovr && lock |=> $stable(mb_mem[last_idx]))
        else $error("locked FIFO overwritten"); // RULE_05
    pend_irq_a: assert property (i_ce && store_ok && cnt_reg == 2'd0 &&
        ier_reg[`CRX_IER_PEND] |=> o_irq_pending) else $error("no pending irq"); // RULE_06
    full_irq_a: assert property (i_ce && store_ok && !rel && cnt_reg == 2'd2 |=>
        full_reg && o_irq_full == $past(ier_reg[`CRX_IER_FULL]))
        else $error("full not signalled"); // RULE_07
    ovr_irq_a: assert property (i_ce && ovr && ier_reg[`CRX_IER_OVR] |=> o_irq_overrun)
        else $error("no overrun irq"); // RULE_08
    filter_drop_a: assert property (i_ce && i_rx_valid && !(|bank_hit) && !rel |=>
        $stable(cnt_reg)) else $error("rejected message stored"); // RULE_10
    btr_lock_a: assert property (wr_btra && !init |=> $stable(btra_reg))
        else $error("timing written outside init"); // RULE_22
    sync_one_a: assert property (i_ce && tq && !init && bt_state == crx_pkg::CRX_BT_SYNC |=>
        bt_state == crx_pkg::CRX_BT_SEG1) else $error("sync segment not one quantum"); // RULE_17
    both_events_a: assert property (i_ce && rel && store_ok |=> $stable(cnt_reg))
        else $error("release and store miscounted"); // RULE_23

    fill_three_c: cover property (i_ce && store_ok && cnt_reg == 2'd2);
    overrun_c: cover property (i_ce && ovr);
    rel_store_c: cover property (i_ce && rel && store_ok);
    sample_c: cover property (o_sample_pulse);
endmodule : crx_top

// ### bench/crx_far_node.sv
// Far-side node model: offers decoded frames and keeps the bus line recessive
`timescale 1ns/1ps
module crx_far_node (
    // Clock
    input  wire logic         i_clk_sys,
    // Frames and bus line
    output logic              o_valid,
    output crx_pkg::crx_msg_t o_msg,
    output logic              o_can_rx,
    output logic              o_bus_idle
);
    initial begin
        o_valid    = 1'b0;
        o_msg      = '0;
        o_can_rx   = 1'b1;
        o_bus_idle = 1'b1;
    end
    // One frame per call, a single-cycle offer
    task send(input logic [10:0] id, input logic [63:0] d);
        @(posedge i_clk_sys);
        o_valid <= 1'b1;
        o_msg   <= '{std_id: id, ext_id: '0, ide: 1'b0, rtr: 1'b0, dlc: 4'h8, data: d};
        @(posedge i_clk_sys);
        o_valid <= 1'b0;
        // Released frame lines no longer show the last value
        o_msg   <= ~o_msg;
    endtask : send
endmodule : crx_far_node

// ### bench/tb.sv
// Register-level testbench for the CAN receive block
`timescale 1ns/1ps
module tb;
    logic                  clk, rst, wt, valid, can_rx, idle;
    logic [31:0]           rdata, q;
    logic [1:0]            cnt;
    logic                  sp, irq_p, irq_f, irq_o, ce, im, sb;
    crx_pkg::crx_avs_req_t avs;
    crx_pkg::crx_msg_t     msg;
    int                    fail_count, cmp_count, n, np, nf, no;
    crx_top i_dut (.i_clk_sys(clk), .i_sys_rst(rst), .i_ce(ce), .i_avs(avs),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wt), .i_rx_valid(valid), .i_rx_msg(msg),
        .i_can_rx(can_rx), .i_bus_idle(idle), .o_init_mode(im), .o_fifo_count(cnt),
        .o_sample_pulse(sp), .o_sample_bit(sb), .o_tx_point(), .o_irq_pending(irq_p),
        .o_irq_full(irq_f), .o_irq_overrun(irq_o));
    crx_far_node u_far (.i_clk_sys(clk), .o_valid(valid), .o_msg(msg), .o_can_rx(can_rx),
        .o_bus_idle(idle));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        np += (irq_p === 1'b1);
        nf += (irq_f === 1'b1);
        no += (irq_o === 1'b1);
    end
    task end_sim;
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_sim
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask : chk
    // One Avalon transfer, held until waitrequest is sampled low
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        avs <= '{read: !wr, write: wr, address: a, writedata: d};
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (wt !== 1'b0 && k < 50);
        @(posedge clk);
        q = rdata;
        avs <= '0;
        if (k >= 50) begin
            fail_count++;
            end_sim();
        end
    endtask : bus
    task rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        chk(nm, e, q);
    endtask : rd
    initial begin
        avs = '0;
        ce  = 1'b1;
        rst = 1'b1;
        {fail_count, cmp_count, np, nf, no} = '0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd("ctrl", 8'h00, 32'h0000_0001);
        rd("timing", 8'h10, 32'h0000_0023);
        rd("unmapped", 8'h30, 32'h0000_0000);
        bus(1'b1, 8'h10, 32'h0000_0034);
        bus(1'b1, 8'h00, 32'h0000_0000);
        bus(1'b1, 8'h10, 32'h0000_0000);
        rd("timing", 8'h10, 32'h0000_0034);
        for (n = 0; n < 100 && sp !== 1'b1; n++) @(posedge clk);
        for (n = 1; n < 100; n++) begin
            @(posedge clk);
            if (sp === 1'b1) break;
        end
        chk("bit length", 32'd10, n);
        chk("init mode", 32'h0000_0000, {31'h0, im});
        chk("sample bit", 32'h0000_0001, {31'h0, sb});
        for (int r = 0; r < 8; r++) bus(1'b1, 8'h40 + 8'(r * 4), 32'h0000_00A5);
        bus(1'b1, 8'h14, 32'h0002_AA3F);
        bus(1'b1, 8'h04, 32'h0000_0007);
        u_far.send(11'h2D0, 64'h9);
        rd("dropped", 8'h08, 32'h0000_0000);
        for (int lk = 0; lk < 2; lk++) begin
            bus(1'b1, 8'h00, 32'(lk * 2));
            for (int k = 1; k < 5; k++) u_far.send(11'h528, 64'(k));
            rd("fifo", 8'h08, 32'h0000_001B);
            chk("irqs", 32'(lk + 1) * 32'h0001_0101, 32'(np * 65536 + nf * 256 + no));
            rd("oldest", 8'h20, 32'h0000_0001);
            bus(1'b1, 8'h08, 32'h0000_0020);
            bus(1'b1, 8'h08, 32'h0000_0020);
            rd("newest", 8'h20, 32'(4 - lk));
            rd("fifo", 8'h08, 32'h0000_0011);
            bus(1'b1, 8'h08, 32'h0000_0030);
            rd("fifo", 8'h08, 32'h0000_0000);
        end
        // Frozen block ignores an accepted frame
        ce <= 1'b0;
        u_far.send(11'h528, 64'h5);
        ce <= 1'b1;
        rd("frozen", 8'h08, 32'h0000_0000);
        end_sim();
    end
endmodule : tb
